// ==== swseq_pkg.sv ====
// Constants and types for the sweep digitiser sequencer
package swseq_pkg;
    localparam int          CLK_HZ         = 50000000;
    localparam int          CONV_CLK_HZ    = 1000000;
    localparam int          CONV_DIV       = CLK_HZ / CONV_CLK_HZ;
    localparam int          BUCKETS        = 601;
    localparam int          ADC_BITS       = 10;
    localparam logic [2:0]  TRIG_FREE      = 3'h0;
    localparam logic [2:0]  TRIG_SINGLE    = 3'h1;
    localparam logic [2:0]  TRIG_EXT       = 3'h2;
    localparam logic [2:0]  TRIG_VIDEO     = 3'h3;
    localparam logic [2:0]  TRIG_LINE      = 3'h4;
    localparam logic [1:0]  SRC_POS        = 2'h0;
    localparam logic [1:0]  SRC_NEG        = 2'h1;
    localparam logic [1:0]  SRC_SAMPLE     = 2'h2;
    localparam logic [1:0]  SRC_RAMP       = 2'h3;
    typedef enum logic [2:0] {SWSEQ_IDLE, SWSEQ_ARM, SWSEQ_START, SWSEQ_BIT, SWSEQ_DONE} swseq_state_t;
endpackage : swseq_pkg

// ==== swseq_top.sv ====
// Sweep digitiser conversion sequencer with trigger select and detector reset timing
// Operation
// - Conversions are successive approximation, resolving one bit per step from the MSB down.
// - The sequencer starts conversions only when the start/stop control permits; a conversion once started runs to its end.
// - In alternating peak mode the converter input alternates between positive and negative detector.
// - The ramp counter value can be switched into the converter for comparison with the sweep ramp.
// - The positive peak detector is reset at the end of every bucket, 601 buckets a sweep.
// - The negative peak detector is reset only at the end of every second bucket.
// - Five trigger sources exist: free run, single, external, video and line.
// - Free run and single triggers come from the 1 MHz converter clock.
// - A qualified trigger from the selected source drives sweep_active high.
// - With a digital video filter of 1 Hz to 100 Hz, sample detection replaces peak detection.
`timescale 1ns/10ps
module swseq_top #(
    parameter int NBITS   = swseq_pkg::ADC_BITS,
    parameter int NBUCKET = swseq_pkg::BUCKETS
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             conv_enable,
    input  wire logic [2:0]       trig_select,
    input  wire logic             single_arm,
    input  wire logic             ext_trigger,
    input  wire logic             video_trigger,
    input  wire logic             line_trigger,
    input  wire logic             alt_peak_mode,
    input  wire logic             digital_vbw,
    input  wire logic             ramp_compare,
    input  wire logic             comparator,
    output logic                  sweep_active,
    output logic [1:0]            adc_source,
    output logic [NBITS-1:0]      dac_value,
    output logic [NBITS-1:0]      conv_result,
    output logic                  conv_valid,
    output logic [9:0]            bucket_index,
    output logic                  pos_peak_reset,
    output logic                  neg_peak_reset,
    output logic                  sweep_done
);
    localparam int DW = $clog2(swseq_pkg::CONV_DIV);
    localparam int BW = $clog2(NBITS);
    localparam logic [DW-1:0] DIV_LAST = DW'(swseq_pkg::CONV_DIV - 1);
    localparam logic [9:0]    LAST_BKT = 10'(NBUCKET - 1);

    swseq_pkg::swseq_state_t state, next_state;
    logic [DW-1:0]    div_cnt, next_div_cnt;
    logic [BW-1:0]    bit_idx, next_bit_idx;
    logic [NBITS-1:0] sar, next_sar;
    logic [NBITS-1:0] next_conv_result;
    logic [9:0]       next_bucket_index;
    logic [1:0]       next_adc_source;
    logic             next_sweep_active, next_conv_valid, next_pos_reset, next_neg_reset, next_sweep_done;
    logic             phase, next_phase;
    logic             single_pend, next_single_pend;
    logic             conv_tick, trig_hit;

    // Converter clock tick from the system clock
    assign conv_tick = (div_cnt == DIV_LAST);

    always_comb begin
        case (trig_select)
            swseq_pkg::TRIG_FREE:   trig_hit = conv_tick;
            swseq_pkg::TRIG_SINGLE: trig_hit = conv_tick && single_pend;
            swseq_pkg::TRIG_EXT:    trig_hit = ext_trigger;
            swseq_pkg::TRIG_VIDEO:  trig_hit = video_trigger;
            swseq_pkg::TRIG_LINE:   trig_hit = line_trigger;
            default:                trig_hit = 1'b0;
        endcase
    end

    always_comb begin
        next_state        = state;
        next_div_cnt      = conv_tick ? '0 : div_cnt + 1'b1;
        next_bit_idx      = bit_idx;
        next_sar          = sar;
        next_conv_result  = conv_result;
        next_bucket_index = bucket_index;
        next_adc_source   = adc_source;
        next_sweep_active = sweep_active;
        next_conv_valid   = 1'b0;
        next_pos_reset    = 1'b0;
        next_neg_reset    = 1'b0;
        next_sweep_done   = 1'b0;
        next_phase        = phase;
        next_single_pend  = single_pend || single_arm;
        case (state)
            swseq_pkg::SWSEQ_IDLE: begin
                if (conv_enable) begin
                    next_state = swseq_pkg::SWSEQ_ARM;
                end
            end
            swseq_pkg::SWSEQ_ARM: begin
                if (!conv_enable) begin
                    next_state = swseq_pkg::SWSEQ_IDLE;
                end else if (trig_hit) begin
                    next_sweep_active = 1'b1;
                    next_bucket_index = '0;
                    next_phase        = 1'b0;
                    if (trig_select == swseq_pkg::TRIG_SINGLE) begin
                        // An arm landing in the trigger cycle is kept for the next sweep
                        next_single_pend = single_arm;
                    end
                    next_state = swseq_pkg::SWSEQ_START;
                end
            end
            swseq_pkg::SWSEQ_START: begin
                if (!conv_enable) begin
                    next_sweep_active = 1'b0;
                    next_state        = swseq_pkg::SWSEQ_IDLE;
                end else if (conv_tick && sweep_active) begin
                    if (ramp_compare) begin
                        next_adc_source = swseq_pkg::SRC_RAMP;
                    end else if (digital_vbw) begin
                        next_adc_source = swseq_pkg::SRC_SAMPLE;
                    end else if (alt_peak_mode) begin
                        next_adc_source = phase ? swseq_pkg::SRC_NEG : swseq_pkg::SRC_POS;
                    end else begin
                        next_adc_source = swseq_pkg::SRC_POS;
                    end
                    next_sar     = {1'b1, {(NBITS-1){1'b0}}};
                    next_bit_idx = BW'(NBITS - 1);
                    next_state   = swseq_pkg::SWSEQ_BIT;
                end
            end
            swseq_pkg::SWSEQ_BIT: begin
                if (conv_tick) begin
                    // Comparator high means trial value exceeds input: drop the bit
                    if (comparator) begin
                        next_sar[bit_idx] = 1'b0;
                    end
                    if (bit_idx == '0) begin
                        next_state = swseq_pkg::SWSEQ_DONE;
                    end else begin
                        next_sar[bit_idx - 1'b1] = 1'b1;
                        next_bit_idx = bit_idx - 1'b1;
                    end
                end
            end
            swseq_pkg::SWSEQ_DONE: begin
                next_conv_result = sar;
                next_conv_valid  = 1'b1;
                next_pos_reset   = 1'b1;
                next_neg_reset   = phase;
                next_phase       = ~phase;
                if (bucket_index == LAST_BKT) begin
                    next_sweep_active = 1'b0;
                    next_sweep_done   = 1'b1;
                    next_state        = swseq_pkg::SWSEQ_IDLE;
                end else begin
                    next_bucket_index = bucket_index + 1'b1;
                    next_state        = swseq_pkg::SWSEQ_START;
                end
            end
            default: next_state = swseq_pkg::SWSEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state          <= swseq_pkg::SWSEQ_IDLE;
            div_cnt        <= '0;
            bit_idx        <= '0;
            sar            <= '0;
            conv_result    <= '0;
            bucket_index   <= '0;
            adc_source     <= swseq_pkg::SRC_POS;
            sweep_active   <= 1'b0;
            conv_valid     <= 1'b0;
            pos_peak_reset <= 1'b0;
            neg_peak_reset <= 1'b0;
            sweep_done     <= 1'b0;
            phase          <= 1'b0;
            single_pend    <= 1'b0;
        end else begin
            state          <= next_state;
            div_cnt        <= next_div_cnt;
            bit_idx        <= next_bit_idx;
            sar            <= next_sar;
            conv_result    <= next_conv_result;
            bucket_index   <= next_bucket_index;
            adc_source     <= next_adc_source;
            sweep_active   <= next_sweep_active;
            conv_valid     <= next_conv_valid;
            pos_peak_reset <= next_pos_reset;
            neg_peak_reset <= next_neg_reset;
            sweep_done     <= next_sweep_done;
            phase          <= next_phase;
            single_pend    <= next_single_pend;
        end
    end

    // Trial word follows the SAR register directly
    assign dac_value = sar;

    sequence s_done;
        conv_valid;
    endsequence

    chk_pos_reset_each: assert property (@(posedge clk) disable iff (reset)
        s_done |-> pos_peak_reset) else $error("positive reset missing at bucket end");
    chk_neg_every_other: assert property (@(posedge clk) disable iff (reset)
        neg_peak_reset |-> !$past(neg_peak_reset, 1) && pos_peak_reset) else $error("negative reset out of step");
    chk_active_on_trig: assert property (@(posedge clk) disable iff (reset)
        (state == swseq_pkg::SWSEQ_ARM && conv_enable && trig_hit) |=> sweep_active) else $error("trigger did not start sweep");
    chk_conv_only_active: assert property (@(posedge clk) disable iff (reset)
        (state == swseq_pkg::SWSEQ_BIT) |-> sweep_active) else $error("conversion outside sweep");
    chk_sweep_end: assert property (@(posedge clk) disable iff (reset)
        sweep_done |-> !sweep_active && $past(bucket_index) == LAST_BKT) else $error("sweep ended at wrong bucket");
    chk_sample_mode: assert property (@(posedge clk) disable iff (reset)
        (state == swseq_pkg::SWSEQ_START && conv_tick && sweep_active && conv_enable && digital_vbw && !ramp_compare)
        |=> adc_source == swseq_pkg::SRC_SAMPLE) else $error("sample detection not selected");
    chk_ramp_route: assert property (@(posedge clk) disable iff (reset)
        (state == swseq_pkg::SWSEQ_START && conv_tick && sweep_active && conv_enable && ramp_compare)
        |=> adc_source == swseq_pkg::SRC_RAMP) else $error("ramp not routed");
    chk_sar_start: assert property (@(posedge clk) disable iff (reset)
        (state == swseq_pkg::SWSEQ_START && next_state == swseq_pkg::SWSEQ_BIT)
        |=> sar[NBITS-1] && bit_idx == BW'(NBITS - 1)) else $error("conversion did not start at MSB");
    chk_stop_ctrl: assert property (@(posedge clk) disable iff (reset)
        (state == swseq_pkg::SWSEQ_IDLE && !conv_enable) |=> state == swseq_pkg::SWSEQ_IDLE) else $error("start without enable");
endmodule : swseq_top

// ==== swseq_conv_model.sv ====
// Behavioural converter front end: comparator against a held analog level
`timescale 1ns/10ps
module swseq_conv_model #(
    parameter int NBITS = 10
) (
    input  wire logic [NBITS-1:0] level,
    input  wire logic [1:0]       adc_source,
    input  wire logic [NBITS-1:0] dac_value,
    output logic                  comparator
);
    logic [NBITS-1:0] held;
    // Negative and ramp paths see the inverted level, so mixing up an inverted and a non-inverted source shows up in the result
    assign held = level ^ {NBITS{adc_source[0]}};
    assign comparator = dac_value > held;
endmodule : swseq_conv_model

// ==== test_sweep_adc_trigger_sequencer.sv ====
// Self-checking bench for the sweep digitiser sequencer
`timescale 1ns/10ps
module test_sweep_adc_trigger_sequencer;
    localparam int NB  = 10;
    localparam int NBK = 4;
    logic          clk, reset, conv_enable, single_arm, ext_trigger, video_trigger, line_trigger;
    logic          alt_peak_mode, digital_vbw, ramp_compare, comparator, sweep_active, conv_valid;
    logic          pos_peak_reset, neg_peak_reset, sweep_done;
    logic [2:0]    trig_select;
    logic [1:0]    adc_source;
    logic [NB-1:0] dac_value, conv_result, level;
    logic [9:0]    bucket_index;
    integer        failures = 0;
    integer        n_checks = 0;
    integer        seed = 32'hA64FEE44;

    swseq_top #(.NBITS(NB), .NBUCKET(NBK)) i_dut (.clk(clk), .reset(reset), .conv_enable(conv_enable),
        .trig_select(trig_select), .single_arm(single_arm), .ext_trigger(ext_trigger),
        .video_trigger(video_trigger), .line_trigger(line_trigger), .alt_peak_mode(alt_peak_mode),
        .digital_vbw(digital_vbw), .ramp_compare(ramp_compare), .comparator(comparator),
        .sweep_active(sweep_active), .adc_source(adc_source), .dac_value(dac_value),
        .conv_result(conv_result), .conv_valid(conv_valid), .bucket_index(bucket_index),
        .pos_peak_reset(pos_peak_reset), .neg_peak_reset(neg_peak_reset), .sweep_done(sweep_done));
    swseq_conv_model #(.NBITS(NB)) i_conv (.level(level), .adc_source(adc_source),
        .dac_value(dac_value), .comparator(comparator));

    task automatic close_out();
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    task automatic check_word(input logic [NB-1:0] got, input logic [NB-1:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check_word

    task automatic check_flag(input logic got, input logic exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s got %b", $time, msg, got);
        end
    endtask : check_flag

    // Priority ramp over sample over alternating over positive
    function automatic logic [1:0] exp_src(input logic a, input logic v, input logic r, input int b);
        if (r)
            return swseq_pkg::SRC_RAMP;
        if (v)
            return swseq_pkg::SRC_SAMPLE;
        if (a && b[0])
            return swseq_pkg::SRC_NEG;
        return swseq_pkg::SRC_POS;
    endfunction : exp_src

    task automatic run_sweep(input logic [2:0] mode, input logic a, input logic v, input logic r);
        int         t;
        int         b;
        logic [1:0] s;
        @(negedge clk);
        level = NB'($random(seed));
        alt_peak_mode = a;
        digital_vbw = v;
        ramp_compare = r;
        trig_select = mode;
        single_arm = (mode == swseq_pkg::TRIG_SINGLE);
        ext_trigger = (mode == swseq_pkg::TRIG_EXT);
        video_trigger = (mode == swseq_pkg::TRIG_VIDEO);
        line_trigger = (mode == swseq_pkg::TRIG_LINE);
        conv_enable = 1'b1;
        // One-cycle arm so no pending arm outlives this sweep
        @(negedge clk);
        single_arm = 1'b0;
        for (t = 0; sweep_active !== 1'b1 && t < 200; t++)
            @(negedge clk);
        check_flag(sweep_active, 1'b1, "sweep not started");
        {single_arm, ext_trigger, video_trigger, line_trigger} = 4'h0;
        for (b = 0; b < NBK; b++) begin
            check_word(bucket_index, NB'(b), "bucket index");
            for (t = 0; conv_valid !== 1'b1 && t < 1000; t++)
                @(negedge clk);
            s = exp_src(a, v, r, b);
            check_word({8'h00, adc_source}, {8'h00, s}, "converter source");
            check_word(conv_result, level ^ {NB{s[0]}}, "conversion result");
            check_flag(pos_peak_reset, 1'b1, "positive detector reset");
            check_flag(neg_peak_reset, b[0], "negative detector reset");
            if (b < NBK - 1)
                @(negedge clk);
        end
        for (t = 0; sweep_done !== 1'b1 && t < 100; t++)
            @(negedge clk);
        check_flag(sweep_done, 1'b1, "sweep end missing");
        conv_enable = 1'b0;
        @(negedge clk);
        check_flag(sweep_active, 1'b0, "active after last bucket");
    endtask : run_sweep

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Seven sweeps of about 2200 cycles each plus idle checks
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        close_out();
    end

    initial begin
        reset = 1'b1;
        {conv_enable, single_arm, ext_trigger, video_trigger, line_trigger} = 5'h00;
        {alt_peak_mode, digital_vbw, ramp_compare} = 3'h0;
        trig_select = swseq_pkg::TRIG_FREE;
        level = 10'h000;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        repeat (200) @(negedge clk);
        check_flag(sweep_active, 1'b0, "sweep without permit");
        conv_enable = 1'b1;
        trig_select = swseq_pkg::TRIG_EXT;
        {video_trigger, line_trigger} = 2'h3;
        repeat (200) @(negedge clk);
        check_flag(sweep_active, 1'b0, "unselected trigger accepted");
        for (int m = 0; m < 5; m++)
            run_sweep(3'(m), 1'($random(seed)), 1'b0, 1'b0);
        run_sweep(swseq_pkg::TRIG_FREE, 1'b1, 1'b1, 1'b0);
        run_sweep(3'({$random(seed)} % 5), 1'b1, 1'b1, 1'b1);
        close_out();
    end
endmodule : test_sweep_adc_trigger_sequencer
